// ### inc/alarm_irq_pkg.sv
// Constants for the per-channel alarm status and interrupt logic
package alarm_irq_pkg;

    // Register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_CHANNELS = 14;
    localparam int CHAN_W = 4;

    // Per-channel register offsets, low nibble of the address
    localparam logic [3:0] OFS_LOOP_CODE_MODE = 4'h3;
    localparam logic [3:0] OFS_ALARM_IRQ_EN = 4'h4;
    localparam logic [3:0] OFS_ALARM_STATUS = 4'h5;
    localparam logic [3:0] OFS_ALARM_CHANGE = 4'h6;

    // Global register addresses
    localparam logic [7:0] ADDR_GLOBAL_IRQ = 8'he0;
    localparam logic [7:0] ADDR_GLOBAL_VIOL = 8'he5;

    // Field positions
    localparam int GLOBAL_IRQ_ENABLE_BIT = 0;
    localparam int VIOL_OVERFLOW_SEL_BIT = 7;
    localparam int LOOP_MODE_LSB = 6;
    localparam int LOOP_MODE_W = 2;

    // Alarm bit positions, shared by enable, status and change registers
    localparam int BIT_EQ_ATTEN = 7;
    localparam int BIT_DRIVER_FAIL = 6;
    localparam int BIT_FIFO_LIMIT = 5;
    localparam int BIT_LINE_VIOLATION = 4;
    localparam int BIT_LOOP_CODE = 3;
    localparam int BIT_ALL_ONES = 2;
    localparam int BIT_SIGNAL_LOSS = 1;
    localparam int BIT_PATTERN_DETECT = 0;

    // Reset values
    localparam logic [7:0] RST_ALARM_IRQ_EN = 8'h00;
    localparam logic [7:0] RST_ALARM_STATUS = 8'h00;
    localparam logic [7:0] RST_ALARM_CHANGE = 8'h00;
    localparam logic [7:0] RST_GLOBAL = 8'h00;
    localparam logic [1:0] RST_LOOP_MODE = 2'h0;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

endpackage

// ### rtl/alarm_channel_slice.sv
// One channel: enable register, live status, change latch, request
`timescale 1ns/100ps
module alarm_channel_slice
    import alarm_irq_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register access
    input wire logic en_wr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic change_clr,
    // Live conditions
    input wire logic [DATA_W-1:0] cond,
    // State
    output logic [DATA_W-1:0] en_q,
    output logic [DATA_W-1:0] status_q,
    output logic [DATA_W-1:0] change_q,
    output logic req
);

    logic [DATA_W-1:0] change_d;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_q <= RST_ALARM_IRQ_EN; // R2
        end else if (en_wr) begin
            en_q <= wr_data; // R1
        end
    end

    // Status follows the conditions regardless of the enables
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_q <= RST_ALARM_STATUS;
        end else begin
            status_q <= cond; // R4
        end
    end

    // New change events win over a clear in the same cycle
    always_comb begin
        change_d = change_q;
        if (change_clr) begin
            change_d = '0; // R15
        end
        change_d = change_d | (cond ^ status_q); // R14
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            change_q <= RST_ALARM_CHANGE;
        end else begin
            change_q <= change_d;
        end
    end

    assign req = |(change_q & en_q); // R1

endmodule // alarm_channel_slice

// ### rtl/channel_alarm_interrupt_logic.sv
// Alarm status and interrupt mask logic for all line channels
//
// Overview of operation
// R1: Each channel has an eight-bit enable register; one allows, zero masks.
// R2: All interrupt enable bits reset to zero.
// R3: Interrupt needs both the per-source enable and the global enable.
// R4: Status bits follow live conditions, read-only, independent of enables.
// R5: Bit 7 shows equalizer attenuation flag.
// R6: Bit 6 shows transmit driver failure.
// R7: Bit 5 shows jitter FIFO pointers within three positions.
// R8: Bit 4 shows line code, bipolar or excess-zeros violation by default.
// R9: Global select bit switches bit 4 to violation counter overflow.
// R10: Bit 3 shows network loop code detected in the selected mode.
// R11: Bit 2 shows all-ones alarm signal received.
// R12: Bit 1 shows receive loss of signal.
// R13: Bit 0 shows quasi-random test pattern detected.
// R14: Any status change latches a change flag that requests an interrupt.
// R15: Change flags clear when software reads their register.
// R16: Interrupt is OR of enabled change requests, level set by parameter.
`timescale 1ns/100ps
module channel_alarm_interrupt_logic
    import alarm_irq_pkg::*;
#(
    parameter int CHANNELS = NUM_CHANNELS,
    parameter bit IRQ_ACTIVE_HIGH = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [alarm_irq_pkg::ADDR_W-1:0] addr,
    input wire logic [alarm_irq_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [alarm_irq_pkg::DATA_W-1:0] rd_data,
    output logic rd_valid,
    // Alarm conditions, one bit per channel
    input wire logic [CHANNELS-1:0] eq_atten_alarm,
    input wire logic [CHANNELS-1:0] driver_fail_alarm,
    input wire logic [CHANNELS-1:0] fifo_limit_alarm,
    input wire logic [CHANNELS-1:0] line_violation,
    input wire logic [CHANNELS-1:0] line_violation_overflow,
    input wire logic [CHANNELS-1:0] loop_code_alarm,
    input wire logic [CHANNELS-1:0] all_ones_alarm,
    input wire logic [CHANNELS-1:0] signal_loss_alarm,
    input wire logic [CHANNELS-1:0] pattern_detect_alarm,
    // Loop code detection mode to the detectors
    output logic [CHANNELS*alarm_irq_pkg::LOOP_MODE_W-1:0] loop_code_mode,
    // Interrupt pin
    output logic irq
);

    import alarm_irq_pkg::*;

    logic [DATA_W-1:0] global_irq_q;
    logic [DATA_W-1:0] global_viol_q;
    logic global_irq_enable;
    logic viol_overflow_sel;
    logic [CHAN_W-1:0] chan_sel;
    logic [3:0] reg_sel;
    logic chan_hit;
    logic [DATA_W-1:0] en_q [CHANNELS];
    logic [DATA_W-1:0] status_q [CHANNELS];
    logic [DATA_W-1:0] change_q [CHANNELS];
    logic [CHANNELS-1:0] req;
    logic [DATA_W-1:0] rd_data_d;

    assign chan_sel = addr[7:4];
    assign reg_sel = addr[3:0];
    assign chan_hit = (32'(chan_sel) < CHANNELS);
    assign global_irq_enable = global_irq_q[GLOBAL_IRQ_ENABLE_BIT];
    assign viol_overflow_sel = global_viol_q[VIOL_OVERFLOW_SEL_BIT];

    // Global registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            global_irq_q <= RST_GLOBAL;
        end else if (wr_en && addr == ADDR_GLOBAL_IRQ) begin
            global_irq_q <= wr_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            global_viol_q <= RST_GLOBAL;
        end else if (wr_en && addr == ADDR_GLOBAL_VIOL) begin
            global_viol_q <= wr_data;
        end
    end

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : gen_chan
            logic [DATA_W-1:0] cond;
            logic sel;
            logic [LOOP_MODE_W-1:0] mode_q;

            assign sel = chan_hit && (32'(chan_sel) == g);

            always_comb begin
                cond = '0;
                cond[BIT_EQ_ATTEN] = eq_atten_alarm[g]; // R5
                cond[BIT_DRIVER_FAIL] = driver_fail_alarm[g]; // R6
                cond[BIT_FIFO_LIMIT] = fifo_limit_alarm[g]; // R7
                cond[BIT_LINE_VIOLATION] = viol_overflow_sel ?
                    line_violation_overflow[g] : // R9
                    line_violation[g]; // R8
                cond[BIT_LOOP_CODE] = loop_code_alarm[g]; // R10
                cond[BIT_ALL_ONES] = all_ones_alarm[g]; // R11
                cond[BIT_SIGNAL_LOSS] = signal_loss_alarm[g]; // R12
                cond[BIT_PATTERN_DETECT] = pattern_detect_alarm[g]; // R13
            end

            // Detection mode steers the external loop code detector
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    mode_q <= RST_LOOP_MODE;
                end else if (wr_en && sel && reg_sel == OFS_LOOP_CODE_MODE) begin
                    mode_q <= wr_data[LOOP_MODE_LSB +: LOOP_MODE_W]; // R10
                end
            end

            assign loop_code_mode[g*LOOP_MODE_W +: LOOP_MODE_W] = mode_q;

            alarm_channel_slice u_slice (
                .clk(clk),
                .rst(rst),
                .en_wr(wr_en && sel && reg_sel == OFS_ALARM_IRQ_EN),
                .wr_data(wr_data),
                .change_clr(rd_en && sel && reg_sel == OFS_ALARM_CHANGE),
                .cond(cond),
                .en_q(en_q[g]),
                .status_q(status_q[g]),
                .change_q(change_q[g]),
                .req(req[g])
            );
        end
    endgenerate

    // Read multiplexer
    always_comb begin
        rd_data_d = UNMAPPED_READ;
        if (addr == ADDR_GLOBAL_IRQ) begin
            rd_data_d = global_irq_q;
        end else if (addr == ADDR_GLOBAL_VIOL) begin
            rd_data_d = global_viol_q;
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                if (chan_hit && 32'(chan_sel) == c) begin
                    unique case (reg_sel)
                        OFS_LOOP_CODE_MODE: begin
                            rd_data_d[LOOP_MODE_LSB +: LOOP_MODE_W] =
                                loop_code_mode[c*LOOP_MODE_W +: LOOP_MODE_W];
                        end
                        OFS_ALARM_IRQ_EN: rd_data_d = en_q[c];
                        OFS_ALARM_STATUS: rd_data_d = status_q[c]; // R4
                        OFS_ALARM_CHANGE: rd_data_d = change_q[c];
                        default: rd_data_d = UNMAPPED_READ;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data <= UNMAPPED_READ;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_en;
            if (rd_en) begin
                rd_data <= rd_data_d;
            end
        end
    end

    // Interrupt pin
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq <= !IRQ_ACTIVE_HIGH;
        end else begin
            irq <= ((|req) && global_irq_enable) ? // R3 R16
                IRQ_ACTIVE_HIGH : !IRQ_ACTIVE_HIGH;
        end
    end

endmodule // channel_alarm_interrupt_logic

// ### testbench/alarm_irq_chk.sv
// Port checker for the alarm interrupt block
`timescale 1ns/100ps
module alarm_irq_chk #(
    parameter int CHANNELS = 14,
    parameter bit IRQ_ACTIVE_HIGH = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    // Alarms and interrupt
    input wire logic [CHANNELS-1:0] eq_atten_alarm,
    input wire logic [CHANNELS-1:0] driver_fail_alarm,
    input wire logic [CHANNELS-1:0] signal_loss_alarm,
    input wire logic [CHANNELS-1:0] pattern_detect_alarm,
    input wire logic irq
);
    logic glob_en_q;
    logic [7:0] en0_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) glob_en_q <= 1'b0;
        else if (wr_en && addr == 8'he0) glob_en_q <= wr_data[0];
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) en0_q <= 8'h00;
        else if (wr_en && addr == 8'h04) en0_q <= wr_data;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    read_pulse_a: assert property (
        rd_valid == $past(rd_en)) else $error("read valid late");
    irq_reset_a: assert property (
        $fell(rst) |-> (irq == !IRQ_ACTIVE_HIGH) [*2]) else $error("irq on");
    irq_gie_a: assert property (
        !glob_en_q |=> irq == !IRQ_ACTIVE_HIGH)
        else $error("irq without global enable");
    en_read_a: assert property (
        rd_en && addr == 8'h04 |=> rd_data == en0_q) else $error("enable");
    eq_status_a: assert property (
        rd_en && addr == 8'h05 |=> rd_data[7] == $past(eq_atten_alarm[0], 2))
        else $error("eq status");
    drv_status_a: assert property (
        rd_en && addr == 8'h05 |=> rd_data[6] == $past(driver_fail_alarm[0], 2))
        else $error("driver status");
    los_status_a: assert property (
        rd_en && addr == 8'h05 |=> rd_data[1] == $past(signal_loss_alarm[0], 2))
        else $error("loss status");
    pat_status_a: assert property (
        rd_en && addr == 8'h05 |=> rd_data[0] == $past(pattern_detect_alarm[0], 2))
        else $error("pattern status");
endmodule // alarm_irq_chk

// ### testbench/alarm_source.sv
// Alarm detector model; lvl[8:1] feed status bits 7..0, lvl[0] overflow
`timescale 1ns/100ps
module alarm_source (
    // Clock and update request
    input wire logic clk,
    input wire logic set,
    input wire logic [3:0] ch,
    input wire logic [8:0] val,
    // Condition levels
    output logic [13:0] lvl [9]
);
    initial for (int i = 0; i < 9; i++) lvl[i] = 14'h0;
    always @(posedge clk) begin
        if (set) for (int i = 0; i < 9; i++) lvl[i][ch] <= val[i];
    end
endmodule // alarm_source

// ### testbench/testbench.sv
// Self-checking bench for the alarm interrupt block
`timescale 1ns/100ps
bind channel_alarm_interrupt_logic alarm_irq_chk #(.CHANNELS(CHANNELS),
    .IRQ_ACTIVE_HIGH(IRQ_ACTIVE_HIGH)) u_chk (.*);
module testbench;
    import alarm_irq_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] rd_data;
    logic rd_valid;
    logic irq;
    logic [27:0] mode;
    logic set = 1'b0;
    logic [3:0] ch = 4'h0;
    logic [8:0] val = 9'h000;
    logic [13:0] lvl [9];
    int err_total = 0;
    int total_checks = 0;
    always #5 clk = ~clk;
    alarm_source u_src (.clk(clk), .set(set), .ch(ch), .val(val), .lvl(lvl));
    channel_alarm_interrupt_logic u_dut (.clk(clk), .rst(rst), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .rd_valid(rd_valid), .eq_atten_alarm(lvl[8]),
        .driver_fail_alarm(lvl[7]), .fifo_limit_alarm(lvl[6]),
        .line_violation(lvl[5]), .line_violation_overflow(lvl[0]),
        .loop_code_alarm(lvl[4]), .all_ones_alarm(lvl[3]),
        .signal_loss_alarm(lvl[2]), .pattern_detect_alarm(lvl[1]),
        .loop_code_mode(mode), .irq(irq));
    task chk(input string n, input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s exp %h saw %h", n, e, s);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask
    task rdc(input logic [7:0] a, input logic [7:0] e);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk("rd_valid", {7'h0, rd_valid}, 8'h01);
        chk("rd_data", rd_data, e);
        @(posedge clk);
    endtask
    task al(input logic [3:0] c, input logic [8:0] v);
        ch <= c;
        val <= v;
        set <= 1'b1;
        @(posedge clk);
        set <= 1'b0;
        @(posedge clk);
    endtask
    // Lets a change reach the latch and the interrupt pin
    task irqc(input logic e);
        repeat (3) @(posedge clk);
        #1;
        chk("irq", {7'h0, irq}, {7'h0, e});
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        give_verdict;
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("irq", {7'h0, irq}, 8'h01);
        for (int c = 0; c < 14; c++) begin
            rdc({c[3:0], OFS_ALARM_IRQ_EN}, RST_ALARM_IRQ_EN);
        end
        rdc(8'h05, 8'h00);
        rdc(8'h06, 8'h00);
        $display("reset test done");
        wr(8'h04, 8'hff);
        rdc(8'h04, 8'hff);
        wr(8'hd4, 8'ha5);
        rdc(8'hd4, 8'ha5);
        wr(8'hf4, 8'h5a);
        rdc(8'hf4, 8'h00);
        wr(8'h05, 8'hff);
        rdc(8'h05, 8'h00);
        wr(8'h04, 8'h00);
        wr(8'h03, 8'hc0);
        chk("mode", {6'h0, mode[1:0]}, 8'h03);
        $display("enable test done");
        for (int i = 0; i < 8; i++) begin
            al(4'h0, 9'h002 << i);
            rdc(8'h05, 8'h01 << i);
        end
        al(4'h0, 9'h021);
        rdc(8'h05, 8'h10);
        wr(8'he5, 8'h80);
        al(4'h0, 9'h020);
        rdc(8'h05, 8'h00);
        al(4'h0, 9'h001);
        rdc(8'h05, 8'h10);
        wr(8'he5, 8'h00);
        al(4'h0, 9'h000);
        irqc(1'b1);
        rdc(8'h06, 8'hff);
        rdc(8'h06, 8'h00);
        $display("status test done");
        wr(8'h04, 8'h02);
        al(4'h0, 9'h004);
        irqc(1'b1);
        wr(8'he0, 8'h01);
        irqc(1'b0);
        rdc(8'h06, 8'h02);
        irqc(1'b1);
        al(4'h0, 9'h006);
        irqc(1'b1);
        rdc(8'h06, 8'h01);
        al(4'hd, 9'h100);
        irqc(1'b0);
        wr(8'he0, 8'h00);
        irqc(1'b1);
        $display("irq test done");
        give_verdict;
    end
endmodule // testbench
